//--- verilog/lane_ctrl_pkg.sv
// Package: register map, field layout and carriers for the lane power and polarity control block
package lane_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Register map (printed offsets are register indexes; byte address is index*4)
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 16;
  localparam logic [7:0]  IDX_POWER_POL     = 8'h3C;
  localparam logic [7:0]  IDX_CLK_DELAY     = 8'h43;
  localparam logic [15:0] RESET_POWER_POL   = 16'h0000;
  localparam logic [15:0] RESET_CLK_DELAY   = 16'h0000;

  // ---------------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------------
  localparam int          NUM_LANES         = 4;
  localparam int          POL_LSB           = 0;
  localparam int          ANA_LSB           = 4;
  localparam int          LINE_LSB          = 8;
  localparam int          DIG_LSB           = 12;
  localparam int          SHIFT_LSB         = 1;
  localparam int          SHIFT_W           = 4;
  localparam int          STEP_PS           = 110;
  localparam logic [15:0] CLK_DELAY_MASK    = 16'h001E;
  localparam logic [15:0] READ_UNMAPPED     = 16'h0000;

  // Per-lane control as seen by the data path
  typedef struct packed {
    logic digital_off;
    logic line_off;
    logic analog_off;
    logic polarity_flip;
  } lane_ctrl_t;

  // One sample word with its test-pattern marker
  typedef struct packed {
    logic        is_pattern;
    logic [13:0] word;
  } sample_t;

endpackage : lane_ctrl_pkg

//--- verilog/lane_data_path.sv
// Lane data path: gating and polarity for one serial output line
`timescale 1ns/1ns
module lane_data_path #(
  parameter int SAMPLE_W = 14
) (
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rstn,
  // Control and sample in
  input  wire lane_ctrl_pkg::lane_ctrl_t i_ctrl,
  input  wire logic                      i_valid,
  input  wire logic [SAMPLE_W-1:0]       i_word,
  input  wire logic                      i_is_pattern,
  // Sample out
  output logic                           o_valid,
  output logic [SAMPLE_W-1:0]            o_word
);

  // Flip only converted samples; patterns pass untouched
  wire logic              flip_now;
  wire logic              pass_now;
  wire logic [SAMPLE_W-1:0] word_next;
  assign flip_now  = i_ctrl.polarity_flip & ~i_is_pattern;
  assign word_next = flip_now ? ~i_word : i_word;
  // A lane whose digital block or line is off sends nothing
  assign pass_now  = i_valid & ~i_ctrl.digital_off & ~i_ctrl.line_off;

  // Output register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_valid <= 1'b0;
      o_word  <= '0;
    end else begin
      o_valid <= pass_now;
      o_word  <= pass_now ? word_next : '0;
    end
  end

  chk_flip_converted: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    pass_now && flip_now |=> o_word == ~$past(i_word))
    else $error("converted sample not inverted");
  chk_pattern_kept: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    pass_now && i_is_pattern |=> o_word == $past(i_word))
    else $error("test pattern altered");

endmodule : lane_data_path

//--- verilog/adc_lane_power_invert_ctrl.sv
// Register bank controlling power-down and polarity of converter lanes 13 to 16 and bit clock shift
`timescale 1ns/1ns
module adc_lane_power_invert_ctrl #(
  parameter int SAMPLE_W = 14
) (
  // Clock and reset
  input  wire logic                                             i_core_clk,
  input  wire logic                                             i_rstn,
  // Register port
  input  wire logic [lane_ctrl_pkg::ADDR_W-1:0]                 i_addr,
  input  wire logic [lane_ctrl_pkg::DATA_W-1:0]                 i_wdata,
  input  wire logic                                             i_wr,
  input  wire logic                                             i_rd,
  output logic      [lane_ctrl_pkg::DATA_W-1:0]                 o_rdata,
  // Samples from the four converters (lane 0 is channel 13)
  input  wire logic [lane_ctrl_pkg::NUM_LANES-1:0]              i_valid,
  input  wire logic [lane_ctrl_pkg::NUM_LANES-1:0][SAMPLE_W-1:0] i_word,
  input  wire logic [lane_ctrl_pkg::NUM_LANES-1:0]              i_is_pattern,
  // Samples to the serialisers
  output logic      [lane_ctrl_pkg::NUM_LANES-1:0]              o_valid,
  output logic      [lane_ctrl_pkg::NUM_LANES-1:0][SAMPLE_W-1:0] o_word,
  // Power controls to the lanes
  output logic      [lane_ctrl_pkg::NUM_LANES-1:0]              o_digital_off,
  output logic      [lane_ctrl_pkg::NUM_LANES-1:0]              o_line_off,
  output logic      [lane_ctrl_pkg::NUM_LANES-1:0]              o_analog_off,
  // Bit clock shift as signed step count
  output logic signed [lane_ctrl_pkg::SHIFT_W-1:0]             o_bit_clock_shift
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  // The sample carrier holds 14 bits, and every control field is one nibble wide,
  // so wider samples or a different lane count cannot be served without new fields
  if (SAMPLE_W < 1 || SAMPLE_W > 14) begin : g_bad_sample_w
    $error("SAMPLE_W out of range");
  end
  if (lane_ctrl_pkg::NUM_LANES != 4) begin : g_bad_lane_count
    $error("NUM_LANES must be 4");
  end

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  logic [15:0] power_pol_reg;
  logic [15:0] clk_delay_reg;
  wire  logic  hit_power_pol;
  wire  logic  hit_clk_delay;
  wire  logic [15:0] rdata_next;
  assign hit_power_pol = i_addr == lane_ctrl_pkg::IDX_POWER_POL;
  assign hit_clk_delay = i_addr == lane_ctrl_pkg::IDX_CLK_DELAY;
  // Unmapped reads return zero so software sees a defined value.
  // The master never raises both strobes at once, so read and write need no priority.
  assign rdata_next = hit_power_pol ? power_pol_reg :
                      hit_clk_delay ? clk_delay_reg : lane_ctrl_pkg::READ_UNMAPPED;

  // Register writes; reserved bits of the delay register are kept at zero.
  // Masking at write time rather than at read time keeps the shift field
  // free of stray bits, so the clock shifter never sees a reserved one.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      power_pol_reg <= lane_ctrl_pkg::RESET_POWER_POL;
      clk_delay_reg <= lane_ctrl_pkg::RESET_CLK_DELAY;
    end else if (i_wr) begin
      if (hit_power_pol) power_pol_reg <= i_wdata;
      if (hit_clk_delay) clk_delay_reg <= i_wdata & lane_ctrl_pkg::CLK_DELAY_MASK;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) o_rdata <= '0;
    else         o_rdata <= i_rd ? rdata_next : '0;
  end

  // ---------------------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------------------
  wire logic [3:0] dig_field;
  wire logic [3:0] line_field;
  wire logic [3:0] ana_field;
  wire logic [3:0] pol_field;
  assign dig_field  = power_pol_reg[lane_ctrl_pkg::DIG_LSB  +: 4];
  assign line_field = power_pol_reg[lane_ctrl_pkg::LINE_LSB +: 4];
  assign ana_field  = power_pol_reg[lane_ctrl_pkg::ANA_LSB  +: 4];
  assign pol_field  = power_pol_reg[lane_ctrl_pkg::POL_LSB  +: 4];

  // Each nibble holds channel 16 at its top bit and channel 13 at its bottom bit,
  // so lane k (channel 13+k) takes bit k of its field. All lane mapping goes
  // through here; a reversal would swap the outer lanes silently.
  function automatic logic [3:0] lane_order(input logic [3:0] f);
    lane_order = f;
  endfunction : lane_order

  // Registered copies keep every output on a flip-flop
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_digital_off     <= '0;
      o_line_off        <= '0;
      o_analog_off      <= '0;
      o_bit_clock_shift <= '0;
    end else begin
      o_digital_off     <= lane_order(dig_field);
      o_line_off        <= lane_order(line_field);
      o_analog_off      <= lane_order(ana_field);
      o_bit_clock_shift <= clk_delay_reg[lane_ctrl_pkg::SHIFT_LSB +: lane_ctrl_pkg::SHIFT_W];
    end
  end

  // ---------------------------------------------------------------------------
  // Lane data paths
  // ---------------------------------------------------------------------------
  wire logic [3:0] pol_lane;
  wire logic [3:0] dig_lane;
  wire logic [3:0] line_lane;
  wire logic [3:0] ana_lane;
  assign pol_lane  = lane_order(pol_field);
  assign dig_lane  = lane_order(dig_field);
  assign line_lane = lane_order(line_field);
  assign ana_lane  = lane_order(ana_field);

  // Controls are taken straight from the register so the next sample sees a write
  for (genvar k = 0; k < lane_ctrl_pkg::NUM_LANES; k++) begin : g_lane
    // The four controls of one lane travel together in one carrier
    wire lane_ctrl_pkg::lane_ctrl_t ctrl_k;
    assign ctrl_k = '{digital_off: dig_lane[k], line_off: line_lane[k],
                      analog_off: ana_lane[k], polarity_flip: pol_lane[k]};
    lane_data_path #(
      .SAMPLE_W (SAMPLE_W)
    ) u_lane (
      .i_core_clk   (i_core_clk),
      .i_rstn       (i_rstn),
      .i_ctrl       (ctrl_k),
      .i_valid      (i_valid[k] & ~ana_lane[k]),
      .i_word       (i_word[k]),
      .i_is_pattern (i_is_pattern[k]),
      .o_valid      (o_valid[k]),
      .o_word       (o_word[k])
    );
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_write_then_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_wr && hit_power_pol ##1 i_rd && hit_power_pol |=> o_rdata == $past(i_wdata, 2))
    else $error("power register readback mismatch");
  chk_delay_reserved: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (clk_delay_reg & ~lane_ctrl_pkg::CLK_DELAY_MASK) == 16'h0000)
    else $error("delay reserved bits set");
  chk_shift_follows: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_wr && hit_clk_delay |=> ##1 o_bit_clock_shift == $past(i_wdata[4:1], 2))
    else $error("bit clock shift not updated");
  chk_digital_gates: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    dig_lane[0] |=> !o_valid[0])
    else $error("digital-off lane still sends");
  chk_line_gates: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    line_lane[3] |=> !o_valid[3])
    else $error("line-off lane still sends");
  chk_analog_gates: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    ana_lane[1] |=> !o_valid[1])
    else $error("analog-off lane still sends");
  chk_flip_next: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_wr && hit_power_pol && i_wdata[0] && !i_wdata[12] && !i_wdata[8] && !i_wdata[4]
    ##1 i_valid[0] && !i_is_pattern[0] |=> o_word[0] == ~$past(i_word[0]))
    else $error("inversion not applied to next sample");
  chk_dig_out: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_wr && hit_power_pol |=> ##1 o_digital_off == lane_order($past(i_wdata[15:12], 2)))
    else $error("digital-off output wrong");

  // Remaining control outputs follow the register two edges after a write
  chk_line_out: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_wr && hit_power_pol |=> ##1 o_line_off == lane_order($past(i_wdata[11:8], 2)))
    else $error("line-off output wrong");
  chk_ana_out: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_wr && hit_power_pol |=> ##1 o_analog_off == lane_order($past(i_wdata[7:4], 2)))
    else $error("analog-off output wrong");

  // Delay register reads back only its shift field
  chk_delay_readback: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_wr && hit_clk_delay ##1 i_rd && hit_clk_delay
    |=> o_rdata == ($past(i_wdata, 2) & lane_ctrl_pkg::CLK_DELAY_MASK))
    else $error("delay register readback wrong");

  // Top lane uses the top invert bit; catches a reversed lane order
  chk_flip_lane3: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_wr && hit_power_pol && i_wdata[3] && !i_wdata[15] && !i_wdata[11] && !i_wdata[7]
    ##1 i_valid[3] && !i_is_pattern[3] |=> o_word[3] == ~$past(i_word[3]))
    else $error("top lane inversion wrong");

  // Leaving reset, every lane runs normally with no clock shift
  chk_reset_clear: assert property (@(posedge i_core_clk)
    $rose(i_rstn) |-> power_pol_reg == lane_ctrl_pkg::RESET_POWER_POL
                   && clk_delay_reg == lane_ctrl_pkg::RESET_CLK_DELAY
                   && o_digital_off == 4'h0
                   && o_line_off == 4'h0
                   && o_analog_off == 4'h0
                   && o_bit_clock_shift == '0)
    else $error("controls not cleared by reset");

endmodule : adc_lane_power_invert_ctrl

//--- testbench/test_adc_lane_power_invert_ctrl.sv
// Self-checking bench for the lane power, polarity and bit clock shift register bank
`timescale 1ns/1ns
module test_adc_lane_power_invert_ctrl;
  // ------------------------------
  // Stimulus, observation, device
  // ------------------------------
  logic              i_core_clk   = 1'b0;
  logic              i_rstn       = 1'b0;
  logic [7:0]        i_addr       = 8'h00;
  logic [15:0]       i_wdata      = 16'h0000;
  logic              i_wr         = 1'b0;
  logic              i_rd         = 1'b0;
  logic [3:0]        i_valid      = 4'h0;
  logic [3:0][13:0]  i_word       = '0;
  logic [3:0]        i_is_pattern = 4'h0;
  logic [15:0]       o_rdata;
  logic [3:0]        o_valid;
  logic [3:0][13:0]  o_word;
  logic [3:0]        o_digital_off;
  logic [3:0]        o_line_off;
  logic [3:0]        o_analog_off;
  logic signed [3:0] o_bit_clock_shift;
  logic [31:0]       seed         = 32'h2EBF30A0;
  int                failures     = 0;
  int                checks       = 0;

  adc_lane_power_invert_ctrl #(.SAMPLE_W(14)) dut_u (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_valid(i_valid), .i_word(i_word),
    .i_is_pattern(i_is_pattern), .o_valid(o_valid), .o_word(o_word), .o_digital_off(o_digital_off),
    .o_line_off(o_line_off), .o_analog_off(o_analog_off), .o_bit_clock_shift(o_bit_clock_shift)
  );

  // 10 MHz clock
  always #50 i_core_clk = ~i_core_clk;

  // ------------------------------
  // Helpers
  // ------------------------------
  // Xorshift keeps every run identical for a given seed
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Any power-down blanks the lane; inversion skips test patterns
  function automatic logic [15:0] expect_lane(input logic [15:0] d, input int i, input logic v,
                                              input logic p, input logic [13:0] w);
    if (!(v & ~d[12+i] & ~d[8+i] & ~d[4+i])) return 16'h0000;
    return {2'b01, (d[i] && !p) ? ~w : w};
  endfunction : expect_lane

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Bus tasks start and end just after a rising edge, so calls chain with no gap
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    @(negedge i_core_clk);
    q = o_rdata;
    @(posedge i_core_clk);
  endtask : rd

  // One random sample on every lane, then lane outputs and power levels
  task automatic send(input logic [15:0] d);
    logic [3:0]       v;
    logic [3:0]       p;
    logic [3:0][13:0] w;
    v = 4'(rnd());
    p = 4'(rnd());
    w = 56'({rnd(), rnd()});
    i_valid      <= v;
    i_is_pattern <= p;
    i_word       <= w;
    @(posedge i_core_clk);
    i_valid      <= 4'h0;
    @(negedge i_core_clk);
    for (int i = 0; i < 4; i++) begin
      check("lane out", {1'b0, o_valid[i], o_word[i]}, expect_lane(d, i, v[i], p[i], w[i]));
    end
    check("digital off", 16'(o_digital_off), 16'(d[15:12]));
    check("line off", 16'(o_line_off), 16'(d[11:8]));
    check("analog off", 16'(o_analog_off), 16'(d[7:4]));
    @(posedge i_core_clk);
  endtask : send

  task automatic reset_dut();
    logic [15:0] q;
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("controls reset", {o_bit_clock_shift, o_digital_off, o_line_off, o_analog_off}, 16'h0000);
    @(posedge i_core_clk);
    rd(lane_ctrl_pkg::IDX_POWER_POL, q);
    check("power reg reset", q, lane_ctrl_pkg::RESET_POWER_POL);
    rd(lane_ctrl_pkg::IDX_CLK_DELAY, q);
    check("delay reg reset", q, lane_ctrl_pkg::RESET_CLK_DELAY);
  endtask : reset_dut

  // ------------------------------
  // Main sequence
  // ------------------------------
  // Corner words first, then random words; samples follow each write at once
  initial begin
    logic [15:0] d;
    logic [15:0] q;
    logic [15:0] codes [5] = '{16'h0000, 16'h0002, 16'h0004, 16'h001C, 16'h001E};
    int          ps    [5] = '{0, 110, 220, -220, -110};
    reset_dut();
    for (int n = 0; n < 40; n++) begin
      d = (n == 0) ? 16'h000F : (n == 1) ? 16'hFFFF : 16'(rnd());
      wr(lane_ctrl_pkg::IDX_POWER_POL, d);
      send(d);
      send(d);
      rd(lane_ctrl_pkg::IDX_POWER_POL, q);
      check("power reg", q, d);
    end
    wr(8'h3D, 16'hFFFF);
    rd(8'h3D, q);
    check("unmapped read", q, lane_ctrl_pkg::READ_UNMAPPED);
    rd(lane_ctrl_pkg::IDX_POWER_POL, q);
    check("power reg kept", q, d);
    // A read right behind a write must already see the new word
    wr(lane_ctrl_pkg::IDX_POWER_POL, ~d);
    rd(lane_ctrl_pkg::IDX_POWER_POL, q);
    check("power reg back to back", q, ~d);
    // Reserved bits are written as ones; only the shift field may stick
    for (int k = 0; k < 5; k++) begin
      wr(lane_ctrl_pkg::IDX_CLK_DELAY, codes[k] | 16'hFFE1);
      rd(lane_ctrl_pkg::IDX_CLK_DELAY, q);
      check("delay reg", q, codes[k]);
      check("clock shift", 16'($signed(o_bit_clock_shift)), 16'(ps[k] / lane_ctrl_pkg::STEP_PS));
    end
    reset_dut();
    give_verdict();
  end

  // Watchdog against a hung run
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
endmodule : test_adc_lane_power_invert_ctrl
